// >>> verilog/hspi_slave.sv
// Purpose: Host command port serial slave, word collection and framing
// Assumes: Host serial clock far below sys_clk_i, sampled as a level
// Notes: Two-wire mode shares the pins; only its filtering lives here
`timescale 1ns/10ps
// What this block does
// - Keep state while serial clock stops
// - Deliver each 16-bit word while selected
// - First read bit after later falling edge
// - Command words back to back, select low
// - Flag error unless a multiple of 8 bits
// - Select rising edge ends and resets port
// - Two-wire mode uses same pins
// - Two-wire filter drops glitches to 50 ns
// - Serial clock up to 1.25 MHz with the 10 MHz sys_clk_i
// - Host reaches all memory and registers
module hspi_slave
  import hspi_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic twi_mode_i,
  input wire logic host_sclk_i,
  input wire logic host_select_n_i,
  input wire logic host_serial_in_i,
  input wire logic [15:0] rd_word_i,
  output logic rd_load_o,
  output logic [15:0] rx_word_o,
  output logic rx_word_valid_o,
  output logic rx_byte_valid_o,
  output logic frame_error_o,
  output logic frame_end_o,
  output logic host_serial_out_o,
  output logic host_serial_out_oe_o
);
  // Synchronised pin levels
  logic sclk_s;
  logic sel_n_s;
  logic din_s;
  // Previous levels for edge finding
  logic sclk_q;
  logic sel_n_q;
  // Edge strobes
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic sel_rise;
  // Receive shift state
  logic [15:0] shift;
  logic [4:0] bit_cnt;
  // Bits seen in current select period
  logic [4:0] total_cnt;
  // Transmit shift state
  logic [15:0] tx_shift;
  // Set by the first rise; until then a fall leaves the first bit standing
  logic tx_armed;
  // Glitch filter state for two-wire mode
  logic [3:0] gl_cnt;
  logic sclk_f;

  // shared pins
  // Same three pins feed both modes
  // serial clock rate
  // Each host clock phase must last four system clocks or more;
  // the full 25 MHz rate needs a faster sampling clock than this one
  hspi_sync u_sync_sclk (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .rst_val_i(1'b0),
    .async_i(host_sclk_i),
    .level_o(sclk_s)
  );
  hspi_sync u_sync_sel (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .rst_val_i(1'b1),
    .async_i(host_select_n_i),
    .level_o(sel_n_s)
  );
  hspi_sync u_sync_din (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .rst_val_i(1'b0),
    .async_i(host_serial_in_i),
    .level_o(din_s)
  );

  // glitch filter
  // Clock level accepted only after staying stable
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      gl_cnt <= 4'h0;
      sclk_f <= 1'b0;
    end else if (sclk_s == sclk_f) begin
      gl_cnt <= 4'h0;
    end else if (gl_cnt >= 4'(HSPI_GLITCH_CYC)) begin
      sclk_f <= sclk_s;
      gl_cnt <= 4'h0;
    end else begin
      gl_cnt <= gl_cnt + 4'h1;
    end
  end

  // Edge memory
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sclk_q <= 1'b0;
      sel_n_q <= 1'b1;
    end else begin
      sclk_q <= twi_mode_i ? sclk_f : sclk_s;
      sel_n_q <= sel_n_s;
    end
  end

  // Edge strobes; serial clock only counts when selected
  assign sclk_rise = ~sel_n_s & ~twi_mode_i & sclk_s & ~sclk_q;
  assign sclk_fall = ~sel_n_s & ~twi_mode_i & ~sclk_s & sclk_q;
  assign sel_fall = sel_n_q & ~sel_n_s;
  assign sel_rise = ~sel_n_q & sel_n_s;

  // sample rising edge
  // Shift in MSB first; no edge means state held
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      shift <= HSPI_WORD_RST;
      bit_cnt <= HSPI_CNT_RST;
    end else if (sel_rise || sel_fall) begin
      shift <= HSPI_WORD_RST;
      bit_cnt <= HSPI_CNT_RST;
    end else if (sclk_rise) begin
      shift <= {shift[14:0], din_s};
      bit_cnt <= (bit_cnt == HSPI_CNT_WORD - 5'h1) ? HSPI_CNT_RST : bit_cnt + 5'h1;
    end
  end

  // Count bits for the period-length check
  // Wraps to one past sixteen, so any whole run of words reads clean
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || sel_fall) begin
      total_cnt <= HSPI_CNT_RST;
    end else if (sclk_rise && total_cnt != HSPI_CNT_WORD) begin
      total_cnt <= total_cnt + 5'h1;
    end else if (sclk_rise) begin
      total_cnt <= 5'h01;
    end
  end

  // word delivery
  // Word handed on after every sixteenth bit
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_word_o <= HSPI_WORD_RST;
      rx_word_valid_o <= 1'b0;
      rx_byte_valid_o <= 1'b0;
    end else begin
      rx_word_valid_o <= sclk_rise && bit_cnt == HSPI_CNT_WORD - 5'h1;
      rx_byte_valid_o <= sel_rise && total_cnt == HSPI_CNT_BYTE;
      if (sclk_rise && bit_cnt == HSPI_CNT_WORD - 5'h1) begin
        rx_word_o <= {shift[14:0], din_s};
      end else if (sel_rise && total_cnt == HSPI_CNT_BYTE) begin
        rx_word_o <= {8'h00, shift[7:0]};
      end
    end
  end

  // end of sequence
  // Select rise flags end and any odd length
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      frame_end_o <= 1'b0;
      frame_error_o <= 1'b0;
    end else begin
      frame_end_o <= sel_rise;
      frame_error_o <= sel_rise && total_cnt != HSPI_CNT_BYTE
        && total_cnt != HSPI_CNT_WORD && total_cnt != HSPI_CNT_RST;
    end
  end

  // core access path
  // Ask for next read word at frame start and word boundary
  assign rd_load_o = (sel_fall && !twi_mode_i)
    || (sclk_fall && tx_armed && bit_cnt == HSPI_CNT_RST);

  // shift on falling edge
  // Load on select fall; a fall shifts only after a rise has been seen,
  // so an idle-low clock moves on at its first fall while an idle-high
  // clock's first fall leaves the first bit standing
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || sel_rise) begin
      tx_shift <= HSPI_WORD_RST;
      tx_armed <= 1'b0;
    end else if (sel_fall && !twi_mode_i) begin
      tx_shift <= rd_word_i;
      tx_armed <= 1'b0;
    end else if (sclk_rise) begin
      // Host has sampled the standing bit
      tx_armed <= 1'b1;
    end else if (sclk_fall && tx_armed && bit_cnt == HSPI_CNT_RST) begin
      // Word boundary, next read word
      tx_shift <= rd_word_i;
    end else if (sclk_fall && tx_armed) begin
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
  end

  // release when deselected
  // Drive MSB only while selected in serial mode
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      host_serial_out_o <= 1'b0;
      host_serial_out_oe_o <= 1'b0;
    end else begin
      host_serial_out_o <= tx_shift[15];
      host_serial_out_oe_o <= ~sel_n_s & ~twi_mode_i;
    end
  end
endmodule // hspi_slave

// >>> verilog/hspi_pkg.sv
// Purpose: Shared constants for the host command port serial slave
// Assumes: System clock of 10 MHz sampling the host serial pins
// Notes: Word and byte framing lengths, glitch filter figures
package hspi_pkg;
  // Bits in one received word
  localparam int unsigned HSPI_WORD_BITS = 16;
  // Bits in one received byte
  localparam int unsigned HSPI_BYTE_BITS = 8;
  // Width of the bit counter
  localparam int unsigned HSPI_CNT_W = 5;
  // Bit counter reset value
  localparam logic [4:0] HSPI_CNT_RST = 5'h00;
  // Last bit position of a word
  localparam logic [4:0] HSPI_CNT_WORD = 5'h10;
  // Last bit position of a byte
  localparam logic [4:0] HSPI_CNT_BYTE = 5'h08;
  // System clock period in ns
  localparam int unsigned HSPI_CLK_NS = 100;
  // Glitch width the two-wire filter rejects, ns
  localparam int unsigned HSPI_GLITCH_NS = 50;
  // Filter cycles, rounded up, at least one
  localparam int unsigned HSPI_GLITCH_CYC =
    (HSPI_GLITCH_NS + HSPI_CLK_NS - 1) / HSPI_CLK_NS;
  // Least select high time, ns
  localparam int unsigned HSPI_SEL_HIGH_NS = 61;
  // Word reset value
  localparam logic [15:0] HSPI_WORD_RST = 16'h0000;
  // Port operating modes
  typedef enum logic {HSPI_MODE_SPI, HSPI_MODE_TWI} hspi_mode_e;
endpackage : hspi_pkg

// >>> verilog/hspi_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to sys_clk_i
// Notes: A change counts once stages two and three agree
`timescale 1ns/10ps
module hspi_sync
  import hspi_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic rst_val_i,
  input wire logic async_i,
  output logic level_o
);
  // Three flops, first read only by second
  logic s1;
  logic s2;
  logic s3;

  // Shift chain
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      // Preset to the idle level so no false edge follows reset
      s1 <= rst_val_i;
      s2 <= rst_val_i;
      s3 <= rst_val_i;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Filtered level, moves only on agreement
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      level_o <= rst_val_i;
    end else if (s2 == s3) begin
      level_o <= s3;
    end
  end
endmodule // hspi_sync

// >>> verification/hspi_asserts.sv
// Purpose: Port checks for the host serial slave
// Assumes: Host keeps select steady 8 cycles or more
// Notes: Bound to hspi_slave
`timescale 1ns/10ps
module hspi_asserts (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic twi_mode_i,
  input wire logic host_select_n_i,
  input wire logic rx_word_valid_o,
  input wire logic rx_byte_valid_o,
  input wire logic frame_error_o,
  input wire logic frame_end_o,
  input wire logic host_serial_out_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Serial mode selected for 8 cycles
  sequence sel_low;
    (!host_select_n_i && !twi_mode_i) [*8];
  endsequence
  // Deselected for 8 cycles
  sequence sel_high;
    host_select_n_i [*8];
  endsequence
  a_oe_on_sel: assert property (sel_low |-> host_serial_out_oe_o)
    else $error("output not driven while selected");
  a_oe_off_sel: assert property (sel_high |-> !host_serial_out_oe_o)
    else $error("output driven while deselected");
  a_word_spacing: assert property (rx_word_valid_o |=> (!rx_word_valid_o) [*8])
    else $error("word pulses too close");
  a_word_in_frame: assert property (rx_word_valid_o |-> !host_select_n_i)
    else $error("word outside a frame");
  a_end_on_rise: assert property (frame_end_o |-> host_select_n_i && $past(frame_end_o) == 0)
    else $error("frame end without deselect");
  a_error_ends: assert property (frame_error_o |-> frame_end_o)
    else $error("frame error away from frame end");
  a_byte_ends: assert property (rx_byte_valid_o |-> frame_end_o && !frame_error_o)
    else $error("byte pulse away from clean frame end");
  a_twi_quiet: assert property (twi_mode_i [*8] |-> !host_serial_out_oe_o && !rx_word_valid_o)
    else $error("serial path active in two-wire mode");
endmodule // hspi_asserts
bind hspi_slave hspi_asserts u_chk (
  .sys_clk_i(sys_clk_i),
  .reset_i(reset_i),
  .twi_mode_i(twi_mode_i),
  .host_select_n_i(host_select_n_i),
  .rx_word_valid_o(rx_word_valid_o),
  .rx_byte_valid_o(rx_byte_valid_o),
  .frame_error_o(frame_error_o),
  .frame_end_o(frame_end_o),
  .host_serial_out_oe_o(host_serial_out_oe_o)
);

// >>> verification/hspi_host.sv
// Purpose: Host master model for the serial slave
// Assumes: Link clock 800 ns, idle low outside frames
// Notes: Reads sampled late in each bit, before the next shift
`timescale 1ns/10ps
module hspi_host (
  input wire logic sys_clk_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic sel_n_o,
  output logic mosi_o,
  output logic [31:0] got_o
);
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
    got_o = 32'h0000_0000;
  end
  // One frame of n bits; clock stopped high in bit 7 and low before bit 8
  task automatic xfer(input int n, input logic [31:0] d, input int hold);
    int i;
    @(posedge sys_clk_i) sel_n_o <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    for (i = 0; i < n; i++) begin
      mosi_o <= d[n-1-i];
      repeat (4 + ((i == 8) ? hold : 0)) @(posedge sys_clk_i);
      sclk_o <= 1'b1;
      repeat (4 + ((i == 7) ? hold : 0)) @(posedge sys_clk_i);
      // sample every bit just before the fall that shifts it
      got_o <= {got_o[30:0], miso_i};
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge sys_clk_i);
    // release, data line no longer holds
    sel_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (12) @(posedge sys_clk_i);
  endtask
endmodule // hspi_host

// >>> verification/hspi_slave_bench.sv
// Purpose: Self-checking bench for the host serial slave
// Assumes: 10 MHz system clock, 800 ns link clock
// Notes: Pulse outputs are counted by a monitor
`timescale 1ns/10ps
module hspi_slave_bench;
  import hspi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic twi = 1'b0;
  // First read word offered by the core model
  localparam logic [15:0] RD_FIRST = 16'h4B2D;
  logic [15:0] rd = RD_FIRST;
  logic rd_load, wv, bv, fe, fd, so, soe, sclk, seln, mosi;
  logic [15:0] rxw;
  logic [31:0] got;
  wire miso = soe ? so : 1'bz;
  int miscompares = 0;
  int n_checks = 0;
  int nw, nb, ne, nd, nl;
  always #50 clk = ~clk;
  hspi_slave uut (.sys_clk_i(clk), .reset_i(rst), .twi_mode_i(twi), .host_sclk_i(sclk),
    .host_select_n_i(seln), .host_serial_in_i(mosi), .rd_word_i(rd), .rd_load_o(rd_load),
    .rx_word_o(rxw), .rx_word_valid_o(wv), .rx_byte_valid_o(bv), .frame_error_o(fe),
    .frame_end_o(fd), .host_serial_out_o(so), .host_serial_out_oe_o(soe));
  hspi_host host (.sys_clk_i(clk), .miso_i(miso), .sclk_o(sclk), .sel_n_o(seln),
    .mosi_o(mosi), .got_o(got));
  // Pulse counters
  always @(posedge clk) begin
    nw <= nw + (wv === 1'b1);
    nb <= nb + (bv === 1'b1);
    ne <= ne + (fe === 1'b1);
    nd <= nd + (fd === 1'b1);
    nl <= nl + (rd_load === 1'b1);
  end
  // Core model: each load request takes the word and offers its inverse next
  always @(posedge clk) begin
    if (rd_load === 1'b1) rd <= ~rd;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic frame(input int n, input logic [31:0] d, input int hold);
    // Clear away from the clock edge so no counter update races the clear
    @(negedge clk);
    nw = 0;
    nb = 0;
    ne = 0;
    nd = 0;
    nl = 0;
    host.xfer(n, d, hold);
  endtask
  // Word with the clock stopped mid-frame
  task automatic t_word;
    frame(16, 32'h0000_A51C, 60);
    chk("word", 32'h0000_A51C, {16'h0000, rxw});
    chk("words", 1, nw);
    chk("read", {16'h0000, RD_FIRST}, {16'h0000, got[15:0]});
    chk("loads", 2, nl);
    chk("released", 0, soe);
    chk("ends", 1, nd);
  endtask
  // Two words in one select low period
  task automatic t_back;
    frame(32, 32'h1357_9BDF, 0);
    chk("last word", 32'h0000_9BDF, {16'h0000, rxw});
    chk("words", 2, nw);
    chk("read", {RD_FIRST, ~RD_FIRST}, got);
    chk("clean", 0, ne);
  endtask
  // Byte frame, bad frame, then recovery
  task automatic t_short;
    frame(8, 32'h0000_005A, 0);
    chk("byte", 32'h0000_005A, {24'h00_0000, rxw[7:0]});
    chk("bytes", 1, nb);
    frame(5, 32'h0000_0015, 0);
    chk("errors", 1, ne);
    frame(16, 32'h0000_6E01, 0);
    chk("after error", 32'h0000_6E01, {16'h0000, rxw});
  endtask
  // Two-wire mode ignores the serial frame
  task automatic t_twi;
    twi <= 1'b1;
    frame(16, 32'h0000_FFFF, 0);
    chk("twi words", 0, nw);
    twi <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // No select edge, load or drive may follow the release of reset
    repeat (8) @(posedge clk);
    chk("reset quiet", 0, nd + nl);
    chk("idle drive", 0, soe);
    t_word();
    t_back();
    t_short();
    t_twi();
    report_and_stop();
  end
endmodule // hspi_slave_bench
